// ===== core/drc_chain.v
// drive reference chain: speed and armature current reference summing and conditioning
//
// How it works
// - two-quadrant clips negative speed to zero
// - ramp bypassed: speed in is ref1 plus ref2
// - ramp on: speed reference one is excluded
// - draw ratio scales ramp output or ref1
// - speed sources: digital, analog, encoder, fieldbus
// - current sources: digital, analog, fieldbus only
// - current-loop analog is unipolar, two-quadrant only
// - flag current limit when demand exceeds limits
// - current reference is signed percent of rated
// - speed loop off: current in is sum
// - speed loop on: current ref one excluded
// - zero torque forces current reference to zero
// - current limits applied as last stage
// - overload none caps digital currents at 100
// - other overload modes cap digital currents 150
// - forward/reverse: zero, pass or negate ramp
`timescale 1ns/10ps
`include "drc_defs.vh"
module drc_chain #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         drive_enable,
	input  wire         drive_start,
	input  wire         four_quadrant_config,
	input  wire         ramp_enable,
	input  wire         speed_reg_enable,
	input  wire         zero_torque,
	input  wire [1:0]   fwd_rev,
	input  wire [1:0]   overload_mode,
	input  wire         draw_on_ramp,
	input  wire [W-1:0] draw_ratio,
	input  wire [2:0]   spd1_sel,
	input  wire [2:0]   spd2_sel,
	input  wire [2:0]   cur1_sel,
	input  wire [2:0]   cur2_sel,
	input  wire [W-1:0] spd1_dig,
	input  wire [W-1:0] spd2_dig,
	input  wire [W-1:0] cur1_dig,
	input  wire [W-1:0] cur2_dig,
	input  wire [W-1:0] ain1,
	input  wire [W-1:0] ain2,
	input  wire [W-1:0] ain3,
	input  wire [2:0]   ain_is_ma,
	input  wire [W-1:0] enc1,
	input  wire [W-1:0] enc2,
	input  wire [W-1:0] fbus_spd1,
	input  wire [W-1:0] fbus_spd2,
	input  wire [W-1:0] fbus_cur1,
	input  wire [W-1:0] fbus_cur2,
	input  wire [W-1:0] ramp_output,
	input  wire [W-1:0] speed_reg_out,
	input  wire [W-1:0] cur_lim_pos,
	input  wire [W-1:0] cur_lim_neg,
	output reg  [W-1:0] ramp_ref_q,
	output reg  [W-1:0] speed_ref_q,
	output reg  [W-1:0] arm_cur_ref_q,
	output reg          cur_limit_q,
	output reg          src_fault_q
);
	localparam signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
	localparam signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

	// saturating signed add; the extra bit catches overflow before it wraps
	function [W-1:0] sat_add;
		input [W-1:0] a;
		input [W-1:0] b;
		reg signed [W:0] s;
		begin
			s = $signed({a[W-1], a}) + $signed({b[W-1], b});
			if (s > $signed({SMAX[W-1], SMAX}))
				sat_add = SMAX;
			else if (s < $signed({SMIN[W-1], SMIN}))
				sat_add = SMIN;
			else
				sat_add = s[W-1:0];
		end
	endfunction

	// negation that maps the most negative value to the most positive
	function [W-1:0] sat_neg;
		input [W-1:0] a;
		begin
			if (a == SMIN)
				sat_neg = SMAX;
			else
				sat_neg = (~a) + {{(W-1){1'b0}}, 1'b1};
		end
	endfunction

	// clamp a signed value between a negative and a positive bound
	function [W-1:0] clamp;
		input [W-1:0] a;
		input [W-1:0] hi;
		input [W-1:0] lo;
		begin
			if ($signed(a) > $signed(hi))
				clamp = hi;
			else if ($signed(a) < $signed(lo))
				clamp = lo;
			else
				clamp = a;
		end
	endfunction

	wire [W-1:0] spd1_v;
	wire [W-1:0] spd2_v;
	wire [W-1:0] cur1_v;
	wire [W-1:0] cur2_v;
	wire         spd1_bad;
	wire         spd2_bad;
	wire         cur1_bad;
	wire         cur2_bad;

	reg  [W-1:0] cur_cap;
	reg  [W-1:0] cur1_dig_c;
	reg  [W-1:0] cur2_dig_c;

	// the overload mode decides how far the digital current setpoints may reach
	always @* begin
		case (overload_mode)
		`DRC_OVL_NONE:    cur_cap = `DRC_PCT_100;
		`DRC_OVL_THERM,
		`DRC_OVL_THERM_M,
		`DRC_OVL_CLIM:    cur_cap = `DRC_PCT_150;
		default:          cur_cap = `DRC_PCT_100;
		endcase
		cur1_dig_c = clamp(cur1_dig, cur_cap, sat_neg(cur_cap));
		cur2_dig_c = clamp(cur2_dig, cur_cap, sat_neg(cur_cap));
	end

	drc_src_sel #(.W(W), .ENC_OK(1)) u_spd1 (
		.sel                  (spd1_sel),
		.dig                  (spd1_dig),
		.ain1                 (ain1),
		.ain2                 (ain2),
		.ain3                 (ain3),
		.ain_is_ma            (ain_is_ma),
		.enc1                 (enc1),
		.enc2                 (enc2),
		.fbus                 (fbus_spd1),
		.four_quadrant_config (four_quadrant_config),
		.val                  (spd1_v),
		.bad                  (spd1_bad)
	);
	drc_src_sel #(.W(W), .ENC_OK(1)) u_spd2 (
		.sel                  (spd2_sel),
		.dig                  (spd2_dig),
		.ain1                 (ain1),
		.ain2                 (ain2),
		.ain3                 (ain3),
		.ain_is_ma            (ain_is_ma),
		.enc1                 (enc1),
		.enc2                 (enc2),
		.fbus                 (fbus_spd2),
		.four_quadrant_config (four_quadrant_config),
		.val                  (spd2_v),
		.bad                  (spd2_bad)
	);
	drc_src_sel #(.W(W), .ENC_OK(0)) u_cur1 (
		.sel                  (cur1_sel),
		.dig                  (cur1_dig_c),
		.ain1                 (ain1),
		.ain2                 (ain2),
		.ain3                 (ain3),
		.ain_is_ma            (ain_is_ma),
		.enc1                 (enc1),
		.enc2                 (enc2),
		.fbus                 (fbus_cur1),
		.four_quadrant_config (four_quadrant_config),
		.val                  (cur1_v),
		.bad                  (cur1_bad)
	);
	drc_src_sel #(.W(W), .ENC_OK(0)) u_cur2 (
		.sel                  (cur2_sel),
		.dig                  (cur2_dig_c),
		.ain1                 (ain1),
		.ain2                 (ain2),
		.ain3                 (ain3),
		.ain_is_ma            (ain_is_ma),
		.enc1                 (enc1),
		.enc2                 (enc2),
		.fbus                 (fbus_cur2),
		.four_quadrant_config (four_quadrant_config),
		.val                  (cur2_v),
		.bad                  (cur2_bad)
	);

	wire               run = drive_enable & drive_start;
	reg  [W-1:0]       ramp_s;
	reg  [W-1:0]       ramp_d;
	reg  [W-1:0]       speed_d;
	reg  [W-1:0]       cur_d;
	reg                lim_d;
	reg  [W-1:0]       spd_a;
	reg  [W-1:0]       cur_a;
	reg  [W-1:0]       cur_sum;
	reg  signed [2*W:0] prod;
	reg  signed [2*W:0] scl;

	always @* begin
		// ramp reference as it would feed the external ramp generator
		ramp_s = sat_add(spd1_v, spd2_v);
		case (fwd_rev)
		`DRC_FR_ZERO: ramp_d = {W{1'b0}};
		`DRC_FR_FWD:  ramp_d = ramp_s;
		`DRC_FR_REV:  ramp_d = sat_neg(ramp_s);
		default:      ramp_d = {W{1'b0}};
		endcase
		if (!four_quadrant_config && ramp_d[W-1])
			ramp_d = {W{1'b0}};

		// speed chain: ramp on replaces reference one by the ramp output
		spd_a = ramp_enable ? ramp_output : spd1_v;
		prod  = $signed({{(W+1){spd_a[W-1]}}, spd_a}) *
			$signed({{(W+1){1'b0}}, draw_ratio});
		scl   = prod >>> `DRC_DRAW_SHIFT;
		if (scl > $signed({{(W+1){1'b0}}, SMAX}))
			spd_a = SMAX;
		else if (scl < $signed({{(W+1){1'b1}}, SMIN}))
			spd_a = SMIN;
		else
			spd_a = scl[W-1:0];
		speed_d = sat_add(spd_a, spd2_v);
		if (!four_quadrant_config && speed_d[W-1])
			speed_d = {W{1'b0}};

		// current chain: signed percent, sign gives direction
		cur_a   = speed_reg_enable ? speed_reg_out : cur1_v;
		cur_sum = sat_add(cur_a, cur2_v);
		if (zero_torque)
			cur_sum = {W{1'b0}};
		cur_d = clamp(cur_sum, cur_lim_pos, cur_lim_neg);
		lim_d = (cur_d != cur_sum);

		if (!run) begin
			ramp_d  = {W{1'b0}};
			speed_d = {W{1'b0}};
			cur_d   = {W{1'b0}};
			lim_d   = 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_ref_q    <= {W{1'b0}};
			speed_ref_q   <= {W{1'b0}};
			arm_cur_ref_q <= {W{1'b0}};
			cur_limit_q   <= 1'b0;
			src_fault_q   <= 1'b0;
		end else begin
			ramp_ref_q    <= ramp_d;
			speed_ref_q   <= speed_d;
			arm_cur_ref_q <= cur_d;
			cur_limit_q   <= lim_d;
			src_fault_q   <= spd1_bad | spd2_bad | cur1_bad | cur2_bad;
		end
	end
endmodule

// ===== core/drc_defs.vh
// constants for the drive reference chain
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH
`define DRC_SRC_DIG      3'h0
`define DRC_SRC_AIN1     3'h1
`define DRC_SRC_AIN2     3'h2
`define DRC_SRC_AIN3     3'h3
`define DRC_SRC_ENC1     3'h4
`define DRC_SRC_ENC2     3'h5
`define DRC_SRC_FBUS     3'h6
`define DRC_FR_ZERO      2'h0
`define DRC_FR_FWD       2'h1
`define DRC_FR_REV       2'h2
`define DRC_OVL_NONE     2'h0
`define DRC_OVL_THERM    2'h1
`define DRC_OVL_THERM_M  2'h2
`define DRC_OVL_CLIM     2'h3
`define DRC_PCT_100      16'h2710
`define DRC_PCT_150      16'h3A98
`define DRC_DRAW_UNITY   16'h4000
`define DRC_DRAW_SHIFT   14
`endif

// ===== core/drc_src_sel.v
// source selector for one reference, with unipolar handling of current-loop inputs
`timescale 1ns/10ps
`include "drc_defs.vh"
module drc_src_sel #(
	parameter W       = 16,
	parameter ENC_OK  = 1
) (
	input  wire [2:0]   sel,
	input  wire [W-1:0] dig,
	input  wire [W-1:0] ain1,
	input  wire [W-1:0] ain2,
	input  wire [W-1:0] ain3,
	input  wire [2:0]   ain_is_ma,
	input  wire [W-1:0] enc1,
	input  wire [W-1:0] enc2,
	input  wire [W-1:0] fbus,
	input  wire         four_quadrant_config,
	output reg  [W-1:0] val,
	output reg          bad
);
	always @* begin
		val = dig;
		bad = 1'b0;
		case (sel)
		`DRC_SRC_DIG:  val = dig;
		`DRC_SRC_AIN1: begin
			val = (ain_is_ma[0] && ain1[W-1]) ? {W{1'b0}} : ain1;
			bad = ain_is_ma[0] & four_quadrant_config;
		end
		`DRC_SRC_AIN2: begin
			val = (ain_is_ma[1] && ain2[W-1]) ? {W{1'b0}} : ain2;
			bad = ain_is_ma[1] & four_quadrant_config;
		end
		`DRC_SRC_AIN3: begin
			val = (ain_is_ma[2] && ain3[W-1]) ? {W{1'b0}} : ain3;
			bad = ain_is_ma[2] & four_quadrant_config;
		end
		`DRC_SRC_ENC1: begin
			val = (ENC_OK != 0) ? enc1 : {W{1'b0}};
			bad = (ENC_OK == 0);
		end
		`DRC_SRC_ENC2: begin
			val = (ENC_OK != 0) ? enc2 : {W{1'b0}};
			bad = (ENC_OK == 0);
		end
		`DRC_SRC_FBUS: val = fbus;
		default: begin
			val = {W{1'b0}};
			bad = 1'b1;
		end
		endcase
		if (bad)
			val = {W{1'b0}};
	end
endmodule

// ===== test/drc_chain_checker.sv
// port assertions for the drive reference chain
`timescale 1ns/10ps
module drc_chain_checker (
	input wire        clk,
	input wire        rst_n,
	input wire        drive_enable,
	input wire        drive_start,
	input wire        four_quadrant_config,
	input wire        ramp_enable,
	input wire        zero_torque,
	input wire [1:0]  fwd_rev,
	input wire [2:0]  spd1_sel,
	input wire [2:0]  spd2_sel,
	input wire [15:0] draw_ratio,
	input wire [15:0] spd1_dig,
	input wire [15:0] spd2_dig,
	input wire [15:0] ramp_output,
	input wire [15:0] cur_lim_pos,
	input wire [15:0] cur_lim_neg,
	input wire [15:0] ramp_ref_q,
	input wire [15:0] speed_ref_q,
	input wire [15:0] arm_cur_ref_q,
	input wire        cur_limit_q
);
	wire run = drive_enable && drive_start;
	// plain sums only: unity draw, digital ref two, sign kept
	wire dig = four_quadrant_config && spd2_sel == 3'h0 && draw_ratio == 16'h4000;
	function [15:0] sat(input [15:0] a, input [15:0] b);
		reg [16:0] s;
		s = {a[15], a} + {b[15], b};
		sat = (s[16] ^ s[15]) ? {s[16], {15{~s[16]}}} : s[15:0];
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_stop;
		!run |=> speed_ref_q == 16'h0000 && ramp_ref_q == 16'h0000 && arm_cur_ref_q == 16'h0000;
	endproperty
	a_stop: assert property (p_stop) else $error("output set while stopped");
	property p_two_q;
		run && !four_quadrant_config |=> !speed_ref_q[15] && !ramp_ref_q[15];
	endproperty
	a_two_q: assert property (p_two_q) else $error("negative reference in 2Q");
	property p_sum;
		run && dig && !ramp_enable && spd1_sel == 3'h0
			|=> speed_ref_q == sat($past(spd1_dig), $past(spd2_dig));
	endproperty
	a_sum: assert property (p_sum) else $error("speed sum wrong");
	property p_ramp;
		run && dig && ramp_enable |=> speed_ref_q == sat($past(ramp_output), $past(spd2_dig));
	endproperty
	a_ramp: assert property (p_ramp) else $error("ref one not excluded");
	property p_fr_zero;
		run && fwd_rev == 2'h0 |=> ramp_ref_q == 16'h0000;
	endproperty
	a_fr_zero: assert property (p_fr_zero) else $error("ramp ref not zeroed");
	property p_zero_tq;
		run && zero_torque && cur_lim_neg[15] && !cur_lim_pos[15] |=> arm_cur_ref_q == 16'h0000;
	endproperty
	a_zero_tq: assert property (p_zero_tq) else $error("torque not zeroed");
	property p_lim_top;
		run |=> $signed(arm_cur_ref_q) <= $signed($past(cur_lim_pos));
	endproperty
	a_lim_top: assert property (p_lim_top) else $error("current above limit");
	property p_lim_flag;
		cur_limit_q |-> arm_cur_ref_q == $past(cur_lim_pos) || arm_cur_ref_q == $past(cur_lim_neg);
	endproperty
	a_lim_flag: assert property (p_lim_flag) else $error("limit flag off bound");
endmodule
bind drc_chain drc_chain_checker u_chk (.*);

// ===== test/testbench.sv
// bench for the drive reference chain
`timescale 1ns/10ps
`include "drc_defs.vh"
module testbench;
	reg         clk, rst_n, drive_enable, drive_start, four_quadrant_config, ramp_enable;
	reg         speed_reg_enable, zero_torque, draw_on_ramp;
	reg  [1:0]  fwd_rev, overload_mode;
	reg  [2:0]  spd1_sel, spd2_sel, cur1_sel, cur2_sel, ain_is_ma;
	reg  [15:0] draw_ratio, spd1_dig, spd2_dig, cur1_dig, cur2_dig, ain1, ain2, ain3, enc1;
	reg  [15:0] enc2, fbus_spd1, fbus_spd2, fbus_cur1, fbus_cur2, ramp_output, speed_reg_out;
	reg  [15:0] cur_lim_pos, cur_lim_neg;
	wire [15:0] ramp_ref_q, speed_ref_q, arm_cur_ref_q;
	wire        cur_limit_q, src_fault_q;
	reg  [48:0] rows [0:3];
	integer     miscompares, checks_done, i;
	drc_chain u_dut (.*);
	always #5 clk = ~clk;
	task chk(input [23:0] n, input [15:0] e, input [15:0] s);
		checks_done = checks_done + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task sm;
		@(posedge clk);
		#1;
	endtask
	task end_of_test;
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// roughly twenty-five times the length of the sequence below
	initial begin
		#20000;
		miscompares = miscompares + 1;
		end_of_test;
	end
	initial begin
		{clk, rst_n, drive_enable, drive_start, ramp_enable, speed_reg_enable, zero_torque,
			draw_on_ramp, overload_mode, spd1_sel, spd2_sel, cur1_sel, cur2_sel, ain_is_ma,
			spd1_dig, spd2_dig, cur1_dig, cur2_dig, fbus_spd2, fbus_cur1, fbus_cur2,
			ramp_output, speed_reg_out, miscompares, checks_done} = 0;
		{ain1, ain2, ain3, enc1, enc2, fbus_spd1} = 96'h000B_0016_0021_002C_0037_0042;
		{four_quadrant_config, fwd_rev, draw_ratio} = {1'b1, `DRC_FR_FWD, `DRC_DRAW_UNITY};
		{cur_lim_pos, cur_lim_neg} = 32'h7FFF_8000;
		rows[0] = {1'b0, 48'hFF00_0080_0000};
		rows[1] = {1'b1, 48'h7FFF_0001_7FFF};
		rows[2] = {1'b1, 48'h8000_FFFF_8000};
		rows[3] = {1'b1, 48'h0064_0032_0096};
		repeat (16) @(posedge clk);
		chk("rst", 16'h0000, speed_ref_q);
		rst_n <= 1'b1;
		drive_enable <= 1'b1;
		spd1_dig <= 16'h0064;
		sm;
		chk("stp", 16'h0000, speed_ref_q);
		@(posedge clk);
		drive_start <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			{four_quadrant_config, spd1_dig, spd2_dig} <= rows[i][48:16];
			sm;
			chk("spd", rows[i][15:0], speed_ref_q);
			@(posedge clk);
		end
		for (i = 0; i < 4; i = i + 1) begin
			fwd_rev <= i[1:0];
			sm;
			chk("rmp", (i == 1) ? 16'h0096 : (i == 2) ? 16'hFF6A : 16'h0000, ramp_ref_q);
			@(posedge clk);
		end
		fwd_rev <= `DRC_FR_FWD;
		ramp_enable <= 1'b1;
		ramp_output <= 16'h012C;
		sm;
		chk("spd", 16'h015E, speed_ref_q);
		@(posedge clk);
		draw_ratio <= 16'h2000;
		sm;
		chk("spd", 16'h00C8, speed_ref_q);
		@(posedge clk);
		ramp_enable <= 1'b0;
		draw_ratio <= `DRC_DRAW_UNITY;
		spd2_dig <= 16'h0000;
		for (i = 1; i < 8; i = i + 1) begin
			spd1_sel <= i[2:0];
			sm;
			chk("spd", (i == 7) ? 16'h0000 : 16'h000B * i[15:0], speed_ref_q);
			@(posedge clk);
		end
		spd1_sel <= `DRC_SRC_AIN1;
		ain_is_ma <= 3'h1;
		sm;
		chk("spd", 16'h0000, speed_ref_q);
		chk("flt", 16'h0001, {15'h0000, src_fault_q});
		@(posedge clk);
		four_quadrant_config <= 1'b0;
		cur1_dig <= 16'h03E8;
		cur2_dig <= 16'h07D0;
		sm;
		chk("spd", 16'h000B, speed_ref_q);
		chk("arm", 16'h0BB8, arm_cur_ref_q);
		@(posedge clk);
		speed_reg_enable <= 1'b1;
		speed_reg_out <= 16'hF63C;
		cur_lim_neg <= 16'hFF38;
		sm;
		chk("arm", 16'hFF38, arm_cur_ref_q);
		chk("lim", 16'h0001, {15'h0000, cur_limit_q});
		@(posedge clk);
		zero_torque <= 1'b1;
		sm;
		chk("arm", 16'h0000, arm_cur_ref_q);
		@(posedge clk);
		zero_torque <= 1'b0;
		speed_reg_enable <= 1'b0;
		cur1_dig <= 16'h4E20;
		cur2_dig <= 16'h0000;
		cur_lim_neg <= 16'h8000;
		for (i = 0; i < 4; i = i + 1) begin
			overload_mode <= i[1:0];
			sm;
			chk("arm", (i == 0) ? `DRC_PCT_100 : `DRC_PCT_150, arm_cur_ref_q);
			@(posedge clk);
		end
		cur1_sel <= `DRC_SRC_ENC1;
		sm;
		chk("arm", 16'h0000, arm_cur_ref_q);
		chk("flt", 16'h0001, {15'h0000, src_fault_q});
		@(posedge clk);
		cur1_sel <= `DRC_SRC_AIN2;
		cur2_sel <= `DRC_SRC_FBUS;
		fbus_cur2 <= 16'h0100;
		sm;
		chk("arm", 16'h0116, arm_cur_ref_q);
		chk("flt", 16'h0000, {15'h0000, src_fault_q});
		@(posedge clk);
		// negative current-loop value must read as zero, not wrap the sum
		ain1 <= 16'hFF00;
		cur1_sel <= `DRC_SRC_AIN1;
		sm;
		chk("arm", 16'h0100, arm_cur_ref_q);
		@(posedge clk);
		four_quadrant_config <= 1'b1;
		ramp_enable <= 1'b1;
		ramp_output <= 16'h7000;
		draw_ratio <= 16'h8000;
		sm;
		chk("spd", 16'h7FFF, speed_ref_q);
		@(posedge clk);
		rst_n <= 1'b0;
		sm;
		chk("rst", 16'h0000, speed_ref_q);
		chk("rst", 16'h0000, arm_cur_ref_q);
		@(posedge clk);
		// the release edge itself still sees reset, so data returns one edge later
		rst_n <= 1'b1;
		sm;
		chk("spd", 16'h7FFF, speed_ref_q);
		end_of_test;
	end
endmodule
